// *** verilog/core_timing_pkg.sv ***
// Shared constants for the sense latch and delay chain block
`default_nettype none
package core_timing_pkg;
   // Delay stage lengths in fast-clock cycles (clk_i at 40 MHz)
   localparam int unsigned CLK_PERIOD_NS  = 25;
   localparam int unsigned DLY1_NS        = 500;
   localparam int unsigned DLY2_NS        = 500;
   localparam int unsigned DLY3_NS        = 250;
   localparam int unsigned DLY1_CYC       = (DLY1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned DLY2_CYC       = (DLY2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned DLY3_CYC       = (DLY3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CNT_W          = 8;
   // Geometry
   localparam int unsigned PLANES         = 8;
   localparam int unsigned DRV_LINES      = 8;
   // Reset values
   localparam logic        LATCH_RST      = 1'b0;
endpackage
`default_nettype wire

// *** verilog/delay_stage.sv ***
// One retriggerable-free delay stage built as a synchronous down counter
`timescale 1ns/10ps
`default_nettype none
module delay_stage #(
   parameter logic [core_timing_pkg::CNT_W-1:0] LEN = 8'h01
) (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Trigger and outputs
   input  wire logic start_i,
   output logic      active_o,
   output logic      done_o
);
   logic [core_timing_pkg::CNT_W-1:0] cnt_ff;
   logic                              active_ff;
   logic                              done_ff;
   wire                               last_w = active_ff && (cnt_ff == 8'h01);

   // Counter runs from LEN down to one; a trigger while busy is ignored
   // so each accepted trigger yields exactly one end pulse
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_ff    <= 8'h00;
         active_ff <= 1'b0;
         done_ff   <= 1'b0;
      end else begin
         done_ff <= last_w;
         if (start_i && !active_ff) begin
            cnt_ff    <= LEN;
            active_ff <= 1'b1;
         end else if (last_w) begin
            cnt_ff    <= 8'h00;
            active_ff <= 1'b0;
         end else if (active_ff) begin
            cnt_ff    <= cnt_ff - 8'h01;
         end
      end
   end

   assign active_o = active_ff;
   assign done_o   = done_ff;
endmodule
`default_nettype wire

// *** verilog/core_sense_latch_and_delay_chain.sv ***
// Sense latches, drive-line gating and three-stage memory timing chain
`timescale 1ns/10ps
`default_nettype none
module core_sense_latch_and_delay_chain (
   // Clock and reset
   input  wire logic                                    clk_i,
   input  wire logic                                    rst_i,
   // System clock pulse and mode pins
   input  wire logic                                    sys_clk_pulse_i,
   input  wire logic                                    single_shot_i,
   input  wire logic                                    inhibit_enable_i,
   input  wire logic                                    write_i,
   input  wire logic                                    latch_clear_request_i,
   // Sense path
   input  wire logic [core_timing_pkg::PLANES-1:0]      sense_i,
   input  wire logic                                    strobe_i,
   // Drive-line selects
   input  wire logic [core_timing_pkg::DRV_LINES-1:0]   drv_sel_a_i,
   input  wire logic [core_timing_pkg::DRV_LINES-1:0]   drv_sel_b_i,
   // Latch state and indicators
   output logic      [core_timing_pkg::PLANES-1:0]      sense_latch_o,
   output logic      [core_timing_pkg::PLANES-1:0]      indicator_o,
   // Drive-line outputs
   output logic      [core_timing_pkg::DRV_LINES-1:0]   drv_on_o,
   // Timing outputs
   output logic                                         delay_one_o,
   output logic                                         delay_two_o,
   output logic                                         delay_three_o,
   output logic                                         gated_inhibit_o,
   output logic                                         latch_clear_o
);
   localparam int unsigned NP = core_timing_pkg::PLANES;
   localparam int unsigned ND = core_timing_pkg::DRV_LINES;

   // Synchroniser ranks for the wide pin groups; only the second rank
   // is read by logic, so a metastable first rank never spreads
   logic [NP-1:0] sense_s1_ff;
   logic [NP-1:0] sense_s2_ff;
   logic [ND-1:0] sela_s1_ff;
   logic [ND-1:0] sela_s2_ff;
   logic [ND-1:0] selb_s1_ff;
   logic [ND-1:0] selb_s2_ff;

   // Synchroniser ranks for the single-bit control pins
   logic          clkp_s1_ff;
   logic          clkp_s2_ff;
   logic          clkp_d_ff;
   logic          sshot_s1_ff;
   logic          sshot_s2_ff;
   logic          inh_en_s1_ff;
   logic          inh_en_s2_ff;
   logic          write_s1_ff;
   logic          write_s2_ff;
   logic          clr_req_s1_ff;
   logic          clr_req_s2_ff;
   logic          strobe_s1_ff;
   logic          strobe_s2_ff;

   // Sense pins; all planes share one pipeline so their timing matches
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sense_s1_ff <= '0;
         sense_s2_ff <= '0;
      end else begin
         sense_s1_ff <= sense_i;
         sense_s2_ff <= sense_s1_ff;
      end
   end

   // Drive-line selects, ground side and supply side
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sela_s1_ff <= '0;
         sela_s2_ff <= '0;
         selb_s1_ff <= '0;
         selb_s2_ff <= '0;
      end else begin
         sela_s1_ff <= drv_sel_a_i;
         sela_s2_ff <= sela_s1_ff;
         selb_s1_ff <= drv_sel_b_i;
         selb_s2_ff <= selb_s1_ff;
      end
   end

   // System clock pulse plus one delayed copy for the edge detector;
   // the copy resets low like the idle pin, so no false edge after reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clkp_s1_ff <= 1'b0;
         clkp_s2_ff <= 1'b0;
         clkp_d_ff  <= 1'b0;
      end else begin
         clkp_s1_ff <= sys_clk_pulse_i;
         clkp_s2_ff <= clkp_s1_ff;
         clkp_d_ff  <= clkp_s2_ff;
      end
   end

   // Mode pins; plain levels, so skew between them is harmless
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sshot_s1_ff  <= 1'b0;
         sshot_s2_ff  <= 1'b0;
         inh_en_s1_ff <= 1'b0;
         inh_en_s2_ff <= 1'b0;
      end else begin
         sshot_s1_ff  <= single_shot_i;
         sshot_s2_ff  <= sshot_s1_ff;
         inh_en_s1_ff <= inhibit_enable_i;
         inh_en_s2_ff <= inh_en_s1_ff;
      end
   end

   // Write indication and latch clear request; both must be settled
   // before delay one and delay two open their gates
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         write_s1_ff   <= 1'b0;
         write_s2_ff   <= 1'b0;
         clr_req_s1_ff <= 1'b0;
         clr_req_s2_ff <= 1'b0;
      end else begin
         write_s1_ff   <= write_i;
         write_s2_ff   <= write_s1_ff;
         clr_req_s1_ff <= latch_clear_request_i;
         clr_req_s2_ff <= clr_req_s1_ff;
      end
   end

   // Strobe; same depth as the sense pipeline so coincidence is kept,
   // a strobe shorter than one clock cycle may be missed
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         strobe_s1_ff <= 1'b0;
         strobe_s2_ff <= 1'b0;
      end else begin
         strobe_s1_ff <= strobe_i;
         strobe_s2_ff <= strobe_s1_ff;
      end
   end

   // Named views of the synchronised controls
   wire clkp_w     = clkp_s2_ff;
   wire sshot_w    = sshot_s2_ff;
   wire inh_en_w   = inh_en_s2_ff;
   wire write_w    = write_s2_ff;
   wire clr_req_w  = clr_req_s2_ff;
   wire strobe_w   = strobe_s2_ff;

   wire clk_rise_w = clkp_w && !clkp_d_ff;

   // Delay chain
   wire d1_act_w;
   wire d1_end_w;
   wire d2_act_w;
   wire d2_end_w;
   wire d3_act_w;

   delay_stage #(.LEN(8'(core_timing_pkg::DLY1_CYC))) u_first_delay_oneshot (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .start_i  (clk_rise_w),
      .active_o (d1_act_w),
      .done_o   (d1_end_w)
   );

   delay_stage #(.LEN(8'(core_timing_pkg::DLY2_CYC))) u_timing_stage_one (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .start_i  (d1_end_w),
      .active_o (d2_act_w),
      .done_o   (d2_end_w)
   );

   delay_stage #(.LEN(8'(core_timing_pkg::DLY3_CYC))) u_timing_stage_two (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .start_i  (d2_end_w),
      .active_o (d3_act_w),
      .done_o   ()
   );

   // inhibit gating, enable bypassed unless single shot
   wire inh_gate_w = d1_act_w && write_w && (inh_en_w || !sshot_w);

   // clear during delay two with request
   wire clear_w = d2_act_w && clr_req_w;

   wire [NP-1:0] qual_w = sense_s2_ff & {NP{strobe_w}};

   // Per-plane latch; clear wins since it is gated to delay two, outside
   // the strobe window of a proper read cycle
   logic [NP-1:0] latch_ff;
   wire  [NP-1:0] nxt_latch;
   genvar g;
   generate
      for (g = 0; g < NP; g++) begin : g_plane
         // set term follows the qualified level
         wire set_w = qual_w[g];
         // clear term reaches every plane alike
         wire clr_w = clear_w;
         // hold unless set or cleared, clear first
         assign nxt_latch[g] = clr_w ? 1'b0 :
                               set_w ? 1'b1 :
                                       latch_ff[g];
      end
   endgenerate

   // Per-line pairing of ground and supply ends; a line conducts
   // only while both of its ends are picked
   // both selects needed
   wire [ND-1:0] drv_pair_w;
   genvar k;
   generate
      for (k = 0; k < ND; k++) begin : g_line
         assign drv_pair_w[k] = sela_s2_ff[k] && selb_s2_ff[k];
      end
   endgenerate

   // Registered outputs, one flop each so no pin shows
   // the glitches of the gating in front of it
   logic [NP-1:0] ind_ff;
   logic [ND-1:0] drv_ff;
   logic          d1_ff;
   logic          d2_ff;
   logic          d3_ff;
   logic          inh_ff;
   logic          clr_ff;

   // Latch and lamp load the same next value, so the lamp never lags
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         latch_ff <= {NP{core_timing_pkg::LATCH_RST}};
         ind_ff   <= {NP{core_timing_pkg::LATCH_RST}};
      end else begin
         latch_ff <= nxt_latch;
         ind_ff   <= nxt_latch;
      end
   end

   // Drive-line outputs; the added flop costs one cycle of latency
   // paired selects registered
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         drv_ff <= '0;
      end else begin
         drv_ff <= drv_pair_w;
      end
   end

   // Timing outputs stay aligned, all one cycle behind the stages
   // delay test outputs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         d1_ff  <= 1'b0;
         d2_ff  <= 1'b0;
         d3_ff  <= 1'b0;
         inh_ff <= 1'b0;
         clr_ff <= 1'b0;
      end else begin
         d1_ff  <= d1_act_w;
         d2_ff  <= d2_act_w;
         d3_ff  <= d3_act_w;
         inh_ff <= inh_gate_w;
         clr_ff <= clear_w;
      end
   end

   assign sense_latch_o   = latch_ff;
   assign indicator_o     = ind_ff;
   assign drv_on_o        = drv_ff;
   assign delay_one_o     = d1_ff;
   assign delay_two_o     = d2_ff;
   assign delay_three_o   = d3_ff;
   assign gated_inhibit_o = inh_ff;
   assign latch_clear_o   = clr_ff;
endmodule
`default_nettype wire

// *** tb/core_chain_sva.sv ***
// Port checker for the sense latch and delay chain
`timescale 1ns/10ps
`default_nettype none
module core_chain_chk (
   input wire logic clk_i, rst_i, sys_clk_pulse_i, single_shot_i, inhibit_enable_i,
   input wire logic write_i, latch_clear_request_i, strobe_i,
   input wire logic [7:0] sense_i, drv_sel_a_i, drv_sel_b_i,
   input wire logic [7:0] sense_latch_o, indicator_o, drv_on_o,
   input wire logic delay_one_o, delay_two_o, delay_three_o, gated_inhibit_o, latch_clear_o
);
   logic [2:0] up_ff;
   // Past inputs count only once the sync pipeline has refilled
   always_ff @(posedge clk_i)
      up_ff <= rst_i ? 3'h0 : up_ff + {2'h0, up_ff != 3'h4};
   wire ok = up_ff == 3'h4;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   drv_pair_a: assert property (ok |-> drv_on_o == $past(drv_sel_a_i & drv_sel_b_i, 3))
      else $error("drive line wrong");
   inh_gate_a: assert property (ok |-> gated_inhibit_o ==
      (delay_one_o & $past(write_i, 3) &
      ($past(inhibit_enable_i, 3) | !$past(single_shot_i, 3)))) else $error("inhibit wrong");
   clr_gate_a: assert property (ok |-> latch_clear_o ==
      (delay_two_o & $past(latch_clear_request_i, 3))) else $error("clear wrong");
   lamp_follow_a: assert property (indicator_o == sense_latch_o)
      else $error("lamp wrong");
   latch_set_a: assert property (ok && !latch_clear_o |->
      sense_latch_o == ($past(sense_latch_o) | $past(sense_i, 3) & {8{$past(strobe_i, 3)}}))
      else $error("latch wrong");
   latch_clr_a: assert property (latch_clear_o |-> sense_latch_o == 8'h00)
      else $error("latch not cleared");
   chain_start_a: assert property (ok && $rose(sys_clk_pulse_i) && !delay_one_o
      |-> ##4 $rose(delay_one_o)) else $error("chain start wrong");
   one_len_a: assert property ($rose(delay_one_o) |-> delay_one_o [*8] ##12 delay_one_o
      ##1 !delay_one_o) else $error("delay one length");
   two_follow_a: assert property ($fell(delay_one_o) |-> !delay_two_o ##1
      delay_two_o ##19 delay_two_o ##1 !delay_two_o) else $error("delay two wrong");
   three_follow_a: assert property ($fell(delay_two_o) |-> !delay_three_o ##1
      delay_three_o ##9 delay_three_o ##1 !delay_three_o) else $error("delay three wrong");
endmodule
bind core_sense_latch_and_delay_chain core_chain_chk u_chk (.clk_i, .rst_i,
   .sys_clk_pulse_i, .single_shot_i, .inhibit_enable_i, .write_i, .latch_clear_request_i,
   .strobe_i, .sense_i, .drv_sel_a_i, .drv_sel_b_i, .sense_latch_o, .indicator_o,
   .drv_on_o, .delay_one_o, .delay_two_o, .delay_three_o, .gated_inhibit_o, .latch_clear_o);
`default_nettype wire

// *** tb/core_array_model.sv ***
// Core plane model: sense pulses and the read strobe
`timescale 1ns/10ps
`default_nettype none
module core_array_model #(parameter int D4 = 5) (
   input  wire logic       clk_i, rd_i, delay_one_i, delay_three_i,
   input  wire logic [7:0] pattern_i,
   output logic      [7:0] sense_o,
   output logic            strobe_o
);
   logic [7:0] rd_sense = 8'h00;
   // Write-time switching pulses the windings too; no strobe goes with it
   assign sense_o = rd_sense | (delay_one_i ? pattern_i : 8'h00);
   initial begin
      strobe_o = 1'b0;
      forever begin
         @(negedge delay_three_i);
         if (rd_i === 1'b1) begin
            repeat (D4) @(posedge clk_i);
            #2 rd_sense = pattern_i;
            @(posedge clk_i) #2 strobe_o = 1'b1;
            @(posedge clk_i) #2 strobe_o = 1'b0;
            @(posedge clk_i) #2 rd_sense = 8'h00;
         end
      end
   end
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the sense latch and delay chain
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic clk = 1'b0, rst = 1'b1, pulse = 1'b0, ss = 1'b0, ie = 1'b0, wr = 1'b0, req = 1'b0;
   logic [7:0] pat = 8'h00, sa = 8'h00, sb = 8'h00, sense, lat, ind, drv, exp_lat = 8'h00;
   logic strobe, d1, d2, d3, inh, clr;
   int errors = 0, total_checks = 0;
   initial forever #12.5 clk = ~clk;
   core_array_model MDL (.clk_i(clk), .rd_i(!wr), .delay_one_i(d1), .delay_three_i(d3),
      .pattern_i(pat), .sense_o(sense), .strobe_o(strobe));
   core_sense_latch_and_delay_chain DUT (.clk_i(clk), .rst_i(rst), .sys_clk_pulse_i(pulse),
      .single_shot_i(ss), .inhibit_enable_i(ie), .write_i(wr), .latch_clear_request_i(req),
      .sense_i(sense), .strobe_i(strobe), .drv_sel_a_i(sa), .drv_sel_b_i(sb),
      .sense_latch_o(lat), .indicator_o(ind), .drv_on_o(drv), .delay_one_o(d1),
      .delay_two_o(d2), .delay_three_o(d3), .gated_inhibit_o(inh), .latch_clear_o(clr));
   task automatic chk(input string what, input logic [7:0] e, g);
      total_checks++;
      if (g !== e) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   // One memory cycle; counts each timing window and judges the latch afterwards
   task automatic run_cycle(input logic w, s, e, r, input logic [7:0] p, input bit again);
      int n1 = 0, n2 = 0, n3 = 0, ni = 0, nc = 0;
      wr = w; ss = s; ie = e; req = r; pat = p; pulse = 1'b1;
      tick(2);
      pulse = 1'b0;
      repeat (100) begin
         tick(1);
         pulse = again && n1 == 5;
         n1 += d1; n2 += d2; n3 += d3; ni += inh; nc += clr;
      end
      exp_lat = (r ? 8'h00 : exp_lat) | (w ? 8'h00 : p);
      chk("delay one", 8'h14, 8'(n1));
      chk("delay two", 8'h14, 8'(n2));
      chk("delay three", 8'h0A, 8'(n3));
      chk("inhibit", (w && (e || !s)) ? 8'h14 : 8'h00, 8'(ni));
      chk("clear", r ? 8'h14 : 8'h00, 8'(nc));
      chk("latch", exp_lat, lat);
      chk("indicator", exp_lat, ind);
   endtask
   task automatic sc_drive;
      for (int i = 0; i < 4; i++) begin
         sa = 8'hF0 >> i;
         sb = 8'h3C << i;
         tick(3);
         chk("drive", sa & sb, drv);
      end
   endtask
   task sc_read; run_cycle(0, 0, 0, 0, 8'hA5, 0); endtask
   task sc_hold_retrig; run_cycle(0, 0, 0, 0, 8'h0F, 1); endtask
   task sc_clear_read; run_cycle(0, 0, 0, 1, 8'h30, 0); endtask
   task sc_write_plain; run_cycle(1, 0, 0, 0, 8'hFF, 0); endtask
   task sc_shot_off; run_cycle(1, 1, 0, 1, 8'hFF, 0); endtask
   task sc_shot_on; run_cycle(1, 1, 1, 0, 8'h00, 0); endtask
   task automatic final_report;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      tick(20);
      rst = 1'b0;
      tick(3);
      sc_drive;
      sc_read;
      sc_hold_retrig;
      sc_clear_read;
      sc_write_plain;
      sc_shot_off;
      sc_shot_on;
      final_report;
   end
   // Whole run is under 800 cycles
   initial begin
      #(25 * 3000);
      errors++;
      final_report;
   end
endmodule
`default_nettype wire
